// [design/exsync_pkg.sv]
// package for the external sync capture block: offsets, fields, reset values
// assumes a 32-bit apb register bus
package exsync_pkg;
  localparam logic [7:0]  OFS_SYNC_CONFIG  = 8'h00;
  localparam logic [7:0]  OFS_RX_MARKER    = 8'h04;
  localparam logic [7:0]  OFS_EDGE_OFFSET  = 8'h08;
  localparam logic [7:0]  OFS_SYNC_STATUS  = 8'h0C;
  localparam logic [7:0]  OFS_SYNC_CMD     = 8'h10;
  localparam int          BIT_TX_SYNC      = 0;
  localparam int          BIT_RX_SYNC      = 1;
  localparam int          BIT_LOCK_TUNE    = 2;
  localparam int          WAIT_LSB         = 3;
  localparam int          WAIT_MSB         = 10;
  localparam int          BIT_TB_RESET     = 11;
  localparam int          CONFIG_BITS      = 12;
  localparam int          OFFSET_BITS      = 6;
  localparam logic [31:0] SYNC_CONFIG_RST  = 32'h0000_0000;
  localparam logic [31:0] CAPTURE_RST      = 32'h0000_0000;
  localparam logic [5:0]  OFFSET_RST       = 6'h00;
  localparam logic [7:0]  WAIT_ZERO        = 8'h00;
  // sub-cycle interval counter: ticks per system clock at 1 ghz over 100 mhz
  localparam int          FINE_GHZ_MHZ     = 1000;
  localparam int          CLOCK_MHZ        = 100;
  localparam logic [5:0]  FINE_PER_CLK     = 6'(FINE_GHZ_MHZ / CLOCK_MHZ);
  typedef enum logic [1:0] {
    EXSYNC_IDLE  = 2'b00,
    EXSYNC_WAIT  = 2'b01,
    EXSYNC_FIRE  = 2'b10
  } exsync_state_e;
endpackage : exsync_pkg

// [design/exsync_oneshot.sv]
// one-shot sync sequencer: waits for external sync, then delays by wait count
// assumes sync_edge is a one-cycle pulse synchronous to clock
`timescale 1ns/1ps
`default_nettype none
module exsync_oneshot
  import exsync_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       arm,
  input  wire logic [7:0] wait_count,
  input  wire logic       sync_edge,
  output logic            fire,
  output logic            busy
);
  exsync_state_e state_r;
  exsync_state_e state_nxt;
  logic [7:0]    cnt_r;
  logic [7:0]    cnt_nxt;
  logic          fire_r;

  // sequence: idle until armed edge, count down wait, pulse fire
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      EXSYNC_IDLE: begin
        if (arm && sync_edge) begin
          state_nxt = (wait_count == WAIT_ZERO) ? EXSYNC_FIRE : EXSYNC_WAIT;
          cnt_nxt   = wait_count;
        end
      end
      EXSYNC_WAIT: begin
        cnt_nxt = cnt_r - 8'h01;
        if (cnt_r == 8'h01) state_nxt = EXSYNC_FIRE;
      end
      default: state_nxt = EXSYNC_IDLE;
    endcase
  end

  // state registers
  always_ff @(posedge clock) begin
    if (reset) begin
      state_r <= EXSYNC_IDLE;
      cnt_r   <= WAIT_ZERO;
      fire_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      fire_r  <= (state_nxt == EXSYNC_FIRE);
    end
  end

  assign fire = fire_r;
  assign busy = (state_r != EXSYNC_IDLE);
endmodule : exsync_oneshot
`default_nettype wire

// [design/exsync_top.sv]
// external sync control and receive-marker capture with an apb register file
// assumes synchronous active-high reset; ext_edge, receive_marker are 1-cycle
// pulses synchronous to clock; fine phase inputs come from a 1 ghz counter
`timescale 1ns/1ps
`default_nettype none
module exsync_top
  import exsync_pkg::*;
(
  input  wire logic                   clock,
  input  wire logic                   reset,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic                        pready,
  output logic [31:0]                 prdata,
  output logic                        pslverr,
  input  wire logic                   ext_edge,
  input  wire logic                   receive_marker,
  input  wire logic [5:0]             marker_phase,
  input  wire logic [5:0]             edge_phase,
  output logic                        oneshot_tx_sync,
  output logic                        oneshot_rx_sync,
  output logic                        oneshot_timebase_reset,
  output logic                        lock_detect_tune,
  output logic [31:0]                 ext_count
);
  logic [CONFIG_BITS-1:0] config_r;
  logic [31:0]            ext_count_r;
  logic [31:0]            captured_ext_count_r;
  logic [5:0]             edge_offset_count_r;
  logic [5:0]             fine_run_r;
  logic                   measuring_r;
  logic                   pready_r;
  logic [31:0]            prdata_r;
  logic                   pslverr_r;
  logic                   tx_fire_r;
  logic                   rx_fire_r;
  logic                   tb_fire_r;
  logic                   lock_tune_r;
  logic [31:0]            ext_count_out_r;

  // bus decode
  wire        setup_w    = psel && !penable;
  wire        access_w   = psel && penable;
  wire        wr_w       = access_w && pwrite;
  wire        hit_cfg_w  = (paddr == OFS_SYNC_CONFIG);
  wire        hit_rx_w   = (paddr == OFS_RX_MARKER);
  wire        hit_off_w  = (paddr == OFS_EDGE_OFFSET);
  wire        hit_sts_w  = (paddr == OFS_SYNC_STATUS);
  wire        mapped_w   = hit_cfg_w || hit_rx_w || hit_off_w || hit_sts_w;
  wire [7:0]  wait_w     = config_r[WAIT_MSB:WAIT_LSB];
  wire        tx_busy_w;
  wire        tb_busy_w;
  wire        tx_fire_w;
  wire        tb_fire_w;
  wire        rx_arm_w   = config_r[BIT_RX_SYNC];
  wire [31:0] status_w   = {29'h0000_0000, measuring_r, tb_busy_w, tx_busy_w};
  wire [31:0] cfg_rd_w   = {20'h0_0000, config_r};
  wire [31:0] off_rd_w   = {26'h000_0000, edge_offset_count_r};
  wire [31:0] rd_mux_w   = hit_cfg_w ? cfg_rd_w :
                           hit_rx_w  ? captured_ext_count_r :
                           hit_off_w ? off_rd_w :
                           hit_sts_w ? status_w : 32'h0000_0000;

  // one-shot transmit sync: armed by bit 0, delayed by wait count
  exsync_oneshot u_tx_shot (
    .clock      (clock),
    .reset      (reset),
    .arm        (config_r[BIT_TX_SYNC]),
    .wait_count (wait_w),
    .sync_edge  (ext_edge),
    .fire       (tx_fire_w),
    .busy       (tx_busy_w)
  );

  // one-shot timebase reset: armed by bit 11, same wait count
  exsync_oneshot u_tb_shot (
    .clock      (clock),
    .reset      (reset),
    .arm        (config_r[BIT_TB_RESET]),
    .wait_count (wait_w),
    .sync_edge  (ext_edge),
    .fire       (tb_fire_w),
    .busy       (tb_busy_w)
  );

  // apb slave: no wait states, error on unmapped or read-only write
  always_ff @(posedge clock) begin
    if (reset) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= setup_w;
      prdata_r  <= setup_w ? rd_mux_w : 32'h0000_0000;
      pslverr_r <= setup_w && (!mapped_w || (pwrite && !hit_cfg_w));
    end
  end

  // configuration register; one-shot bits self-clear when their shot fires
  always_ff @(posedge clock) begin
    if (reset) begin
      config_r <= SYNC_CONFIG_RST[CONFIG_BITS-1:0];
    end else if (wr_w && pready_r && hit_cfg_w) begin
      config_r <= pwdata[CONFIG_BITS-1:0];
    end else begin
      if (tx_fire_w) config_r[BIT_TX_SYNC] <= 1'b0;
      if (tb_fire_w) config_r[BIT_TB_RESET] <= 1'b0;
      if (rx_arm_w && receive_marker) config_r[BIT_RX_SYNC] <= 1'b0;
    end
  end

  // external clock counter, cleared by the timebase reset shot
  always_ff @(posedge clock) begin
    if (reset) begin
      ext_count_r <= CAPTURE_RST;
    end else if (tb_fire_w) begin
      ext_count_r <= CAPTURE_RST;
    end else if (ext_edge) begin
      ext_count_r <= ext_count_r + 32'h0000_0001;
    end
  end

  // marker capture and 1 ghz interval measure; held until next marker
  always_ff @(posedge clock) begin
    if (reset) begin
      captured_ext_count_r <= CAPTURE_RST;
      edge_offset_count_r  <= OFFSET_RST;
      fine_run_r           <= OFFSET_RST;
      measuring_r          <= 1'b0;
    end else if (receive_marker) begin
      captured_ext_count_r <= ext_count_r;
      fine_run_r           <= FINE_PER_CLK - marker_phase;
      measuring_r          <= 1'b1;
    end else if (measuring_r && ext_edge) begin
      edge_offset_count_r  <= fine_run_r + edge_phase;
      measuring_r          <= 1'b0;
    end else if (measuring_r) begin
      fine_run_r           <= fine_run_r + FINE_PER_CLK;
    end
  end

  // registered outputs
  always_ff @(posedge clock) begin
    if (reset) begin
      tx_fire_r       <= 1'b0;
      rx_fire_r       <= 1'b0;
      tb_fire_r       <= 1'b0;
      lock_tune_r     <= 1'b0;
      ext_count_out_r <= CAPTURE_RST;
    end else begin
      tx_fire_r       <= tx_fire_w;
      rx_fire_r       <= rx_arm_w && receive_marker;
      tb_fire_r       <= tb_fire_w;
      lock_tune_r     <= config_r[BIT_LOCK_TUNE];
      ext_count_out_r <= ext_count_r;
    end
  end

  assign pready                 = pready_r;
  assign prdata                 = prdata_r;
  assign pslverr                = pslverr_r;
  assign oneshot_tx_sync        = tx_fire_r;
  assign oneshot_rx_sync        = rx_fire_r;
  assign oneshot_timebase_reset = tb_fire_r;
  assign lock_detect_tune       = lock_tune_r;
  assign ext_count              = ext_count_out_r;
endmodule : exsync_top
`default_nettype wire

// [verification/exsync_refclk.sv]
// external reference clock model: one edge pulse every PERIOD cycles
// assumes the bench supplies the sub-cycle phase of each edge
`timescale 1ns/1ps
`default_nettype none
module exsync_refclk #(
  parameter int PERIOD = 20
) (
  input  wire logic [0:0] clock,
  input  wire logic       reset,
  input  wire logic [5:0] phase,
  output logic            ext_edge,
  output logic [5:0]      edge_phase
);
  int cnt_r;
  // free-running divider; phase means nothing between edges, so it toggles
  always_ff @(posedge clock) begin
    cnt_r      <= (reset || cnt_r == PERIOD - 1) ? 0 : cnt_r + 1;
    ext_edge   <= !reset && cnt_r == PERIOD - 1;
    edge_phase <= reset ? 6'h00 : (cnt_r == PERIOD - 1) ? phase : ~edge_phase;
  end
endmodule : exsync_refclk
`default_nettype wire

// [verification/exsync_chk.sv]
// port assertions for the external sync block, bound into exsync_top
// assumes one clock and synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module exsync_chk (
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        ext_edge,
  input wire logic        receive_marker,
  input wire logic        oneshot_tx_sync,
  input wire logic        oneshot_rx_sync,
  input wire logic        oneshot_timebase_reset,
  input wire logic        lock_detect_tune
);
  import exsync_pkg::*;
  logic [11:0] cfg_r;
  // decode of accepted config writes and offset reads
  wire         wr_cfg = psel && penable && pwrite && pready && paddr == OFS_SYNC_CONFIG;
  wire         rd_ofs = psel && penable && !pwrite && pready && paddr == OFS_EDGE_OFFSET;
  wire [11:0]  fired = {oneshot_timebase_reset, 9'h000, oneshot_rx_sync, oneshot_tx_sync};
  // config mirror, an arm bit drops once its pulse is seen
  always_ff @(posedge clock)
    cfg_r <= reset ? 12'h000 : wr_cfg ? pwdata[11:0] : cfg_r & ~fired;
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  a_ready_one: assert property (psel && !penable |=> pready) else $error("no ready");
  a_tune_copy: assert property ($rose(cfg_r[2]) |-> ##[0:1] lock_detect_tune)
    else $error("tune not copied");
  a_tx_armed: assert property (oneshot_tx_sync |-> cfg_r[0]) else $error("tx unarmed");
  a_tx_nowait: assert property (ext_edge && cfg_r[0] && cfg_r[10:3] == WAIT_ZERO
    |-> ##2 oneshot_tx_sync) else $error("tx late");
  a_tb_nowait: assert property (ext_edge && cfg_r[11] && cfg_r[10:3] == WAIT_ZERO
    |-> ##2 oneshot_timebase_reset) else $error("tb late");
  a_rx_fire: assert property (receive_marker && cfg_r[1] |=> oneshot_rx_sync)
    else $error("rx missing");
  a_rx_cause: assert property (oneshot_rx_sync |-> $past(receive_marker))
    else $error("rx no marker");
  a_rx_armed: assert property (oneshot_rx_sync |-> $past(cfg_r[1]))
    else $error("rx unarmed");
  a_upper_zero: assert property (rd_ofs |-> prdata[31:6] == 26'h000_0000)
    else $error("upper bits set");
  c_tx: cover property (oneshot_tx_sync);
  c_tb: cover property (oneshot_timebase_reset);
  c_rx: cover property (oneshot_rx_sync);
endmodule : exsync_chk
bind exsync_top exsync_chk chk_u (.clock(clock), .reset(reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .ext_edge(ext_edge), .receive_marker(receive_marker),
  .oneshot_tx_sync(oneshot_tx_sync), .oneshot_rx_sync(oneshot_rx_sync),
  .oneshot_timebase_reset(oneshot_timebase_reset), .lock_detect_tune(lock_detect_tune));
`default_nettype wire

// [verification/exsync_top_test.sv]
// self-checking bench for exsync_top over apb
// assumes exsync_refclk makes the external edges, checker bound separately
`timescale 1ns/1ps
`default_nettype none
module exsync_top_test;
  import exsync_pkg::*;
  logic        clock, reset, psel, penable, pwrite, marker, pready, pslverr;
  logic        edge_p, tx, rx, tb, tune, e;
  logic [7:0]  paddr, w;
  logic [31:0] pwdata, prdata, q, cnt;
  logic [5:0]  mph, eph;
  int          mismatches, checks, n, ecount, cap, off;
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  exsync_top dut_u (.clock(clock), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .ext_edge(edge_p), .receive_marker(marker), .marker_phase(mph),
    .edge_phase(eph), .oneshot_tx_sync(tx), .oneshot_rx_sync(rx),
    .oneshot_timebase_reset(tb), .lock_detect_tune(tune), .ext_count(cnt));
  exsync_refclk ref_u (.clock(clock), .reset(reset), .phase(6'h04), .ext_edge(edge_p),
    .edge_phase(eph));
  // edges since the last timebase reset, the expected counter value
  always @(posedge clock)
    ecount <= (reset || tb) ? 0 : ecount + int'(edge_p);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report
  // bounded wait for a signal high at a rising edge; n counts edges
  task automatic wt(ref logic s, output int n);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (s !== 1'b1 && n < 300);
    if (s !== 1'b1) begin
      chk(32'h0000_0001, 32'h0000_0000);
      final_report();
    end
  endtask : wt
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clock);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    wt(pready, k);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000);
    chk(q, x);
  endtask : rd
  initial begin
    {psel, penable, pwrite, marker, paddr, pwdata, mph} = '0;
    reset = 1'b1;
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    rd(OFS_SYNC_CONFIG, SYNC_CONFIG_RST);
    rd(OFS_EDGE_OFFSET, 32'h0000_0000);
    rd(8'h14, 32'h0000_0000);
    chk(32'(e), 32'h0000_0001);
    apb(1'b1, OFS_RX_MARKER, 32'hFFFF_FFFF);
    chk(32'(e), 32'h0000_0001);
    rd(OFS_RX_MARKER, CAPTURE_RST);
    apb(1'b1, OFS_SYNC_CONFIG, 32'hFFFF_F004);
    rd(OFS_SYNC_CONFIG, 32'h0000_0004);
    chk(32'(tune), 32'h0000_0001);
    // both one-shots, wait count zero and five
    for (int i = 0; i < 4; i++) begin
      w = i[1] ? 8'h05 : 8'h00;
      apb(1'b1, OFS_SYNC_CONFIG, {20'h0_0000, i[0], w, 1'h1, 1'h0, !i[0]});
      wt(edge_p, n);
      if (i[0]) wt(tb, n);
      else wt(tx, n);
      chk(32'(n), 32'(w) + 32'h0000_0002);
      rd(OFS_SYNC_CONFIG, {21'h00_0000, w, 3'h4});
    end
    // receive marker three cycles before an edge
    apb(1'b1, OFS_SYNC_CONFIG, 32'h0000_0006);
    wt(edge_p, n);
    repeat (16) @(posedge clock);
    chk(cnt, 32'(ecount));
    marker <= 1'b1;
    mph    <= 6'h03;
    @(posedge clock);
    marker <= 1'b0;
    mph    <= 6'h2A;
    cap = ecount;
    wt(edge_p, n);
    off = 10 - 3 + 10 * (n - 1) + 4;
    rd(OFS_RX_MARKER, 32'(cap));
    rd(OFS_EDGE_OFFSET, 32'(off));
    rd(OFS_SYNC_CONFIG, 32'h0000_0004);
    wt(edge_p, n);
    rd(OFS_RX_MARKER, 32'(cap));
    rd(OFS_EDGE_OFFSET, 32'(off));
    // second marker with the receive one-shot disarmed: capture still updates
    marker <= 1'b1;
    mph    <= 6'h09;
    @(posedge clock);
    marker <= 1'b0;
    mph    <= 6'h15;
    cap = ecount;
    rd(OFS_SYNC_STATUS, 32'h0000_0004);
    wt(edge_p, n);
    rd(OFS_SYNC_STATUS, 32'h0000_0000);
    rd(OFS_RX_MARKER, 32'(cap));
    chk(cnt, 32'(ecount));
    final_report();
  end
endmodule : exsync_top_test
`default_nettype wire
